/* inc/scrb_pkg.sv */
// Package for the socket control register bank.
// Assumes one clock domain, classic Wishbone slave with 32-bit data.
package scrb_pkg;

	// ----------------------------------------
	// Wishbone word offsets (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] OFS_SELECTOR = 4'h0;
	localparam logic [3:0] OFS_DATA_PORT = 4'h4;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
	// Clear is the write side of the status word
	localparam logic [3:0] OFS_IRQ_CLEAR = 4'h8;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'hC;
	localparam logic [1:0] IRQ_PAGE_MAIN = 2'h0;

	// ----------------------------------------
	// Indexed register numbers
	// ----------------------------------------
	localparam logic [5:0] IDX_CHIP_REVISION_ID = 6'h00;
	localparam logic [5:0] IDX_SOCKET_INTERFACE_STATUS = 6'h01;
	localparam logic [5:0] IDX_SOCKET_POWER_CONTROL = 6'h02;
	localparam logic [5:0] IDX_SOCKET_INTERRUPT_GENERAL_CONTROL = 6'h03;
	localparam logic [5:0] IDX_CARD_STATUS_CHANGE_FLAGS = 6'h04;
	localparam logic [5:0] IDX_MANAGEMENT_INTERRUPT_CONFIG = 6'h05;
	localparam logic [5:0] IDX_WINDOW_MAPPING_ENABLE = 6'h06;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int SEL_SOCKET_BIT = 6;
	localparam int STAT_ALWAYS_ONE_BIT = 7;
	localparam int STAT_READY_BIT = 5;
	localparam int STAT_WP_BIT = 4;
	localparam int MAP_RESERVED_BIT = 5;
	localparam logic [1:0] REV_INTERFACE_ID = 2'h1; // Arbitrary value
	localparam logic [3:0] REV_STEPPING = 4'h1; // Arbitrary value
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] MAP_WRITE_MASK = 8'hDF;
	localparam int NUM_SOCKETS = 2;
	localparam int NUM_EVENTS = 4;

	// Card pins of one socket
	typedef struct packed {
		logic card_ready_irq_pin;
		logic write_protect_io16_pin;
		logic card_present_n_b;
		logic card_present_n_a;
		logic battery_sense_b_pin;
		logic battery_sense_a_pin;
	} scrb_pins_s;

	// Writable state of one socket
	typedef struct packed {
		logic [7:0] power;
		logic [7:0] int_gen;
		logic [3:0] change;
		logic [7:0] mgmt_cfg;
		logic [7:0] map_en;
		scrb_pins_s prev;
	} scrb_sock_s;

endpackage

/* src/scrb_socket_regs.sv */
// Per-socket register storage, one instance per socket.
// Assumes pins are synchronous to CORE_CLK; write strobe is one cycle.
`timescale 1ns/1ps
module scrb_socket_regs
	import scrb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire scrb_pkg::scrb_pins_s pins,
	input wire logic wr,
	input wire logic rd,
	input wire logic [5:0] idx,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic [3:0] change,
	output logic [3:0] mgmt_level,
	output logic event_any
);
	scrb_sock_s st_q, st_d;
	logic [3:0] ev;
	logic [7:0] rsel;

	// ----------------------------------------
	// Event detection and register update
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		ev[3] = (pins.card_present_n_a != st_q.prev.card_present_n_a)
			| (pins.card_present_n_b != st_q.prev.card_present_n_b);
		ev[2] = pins.card_ready_irq_pin & ~st_q.prev.card_ready_irq_pin;
		ev[1] = pins.battery_sense_b_pin != st_q.prev.battery_sense_b_pin;
		ev[0] = pins.battery_sense_a_pin != st_q.prev.battery_sense_a_pin;
		st_d.prev = pins;
		// Flags clear on read; a new event wins over the clear
		if (rd && idx == IDX_CARD_STATUS_CHANGE_FLAGS) begin
			st_d.change = 4'h0;
		end
		// RL10 - enabled event sets
		st_d.change = st_d.change | (ev & st_q.mgmt_cfg[3:0]);
		if (wr) begin
			unique case (idx)
				IDX_SOCKET_POWER_CONTROL: st_d.power = wdata;
				IDX_SOCKET_INTERRUPT_GENERAL_CONTROL: st_d.int_gen = wdata;
				// RL8 - level and enables
				IDX_MANAGEMENT_INTERRUPT_CONFIG: st_d.mgmt_cfg = wdata;
				IDX_WINDOW_MAPPING_ENABLE: st_d.map_en = wdata & MAP_WRITE_MASK;
				default: st_d.power = st_d.power;
			endcase
		end
		rsel = RST_BYTE;
		unique case (idx)
			// RL6 - fixed revision
			IDX_CHIP_REVISION_ID: rsel = {REV_INTERFACE_ID, 2'b00, REV_STEPPING};
			// RL1 fixed one, RL2 - RL5 live pin levels
			IDX_SOCKET_INTERFACE_STATUS: rsel = {1'b1, st_q.power[4],
				pins.card_ready_irq_pin, pins.write_protect_io16_pin,
				~pins.card_present_n_b, ~pins.card_present_n_a,
				pins.battery_sense_b_pin, pins.battery_sense_a_pin};
			IDX_SOCKET_POWER_CONTROL: rsel = st_q.power;
			IDX_SOCKET_INTERRUPT_GENERAL_CONTROL: rsel = st_q.int_gen;
			// RL7 - upper bits zero
			IDX_CARD_STATUS_CHANGE_FLAGS: rsel = {4'h0, st_q.change};
			IDX_MANAGEMENT_INTERRUPT_CONFIG: rsel = st_q.mgmt_cfg;
			IDX_WINDOW_MAPPING_ENABLE: rsel = st_q.map_en;
			default: rsel = RST_BYTE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
			rdata <= RST_BYTE;
			event_any <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			rdata <= rsel;
			event_any <= |(ev & st_q.mgmt_cfg[3:0]);
		end
	end

	assign change = st_q.change;
	assign mgmt_level = st_q.mgmt_cfg[7:4];

	// RL1 - status top bit
	property p_stat_top;
		@(posedge clk) disable iff (rst)
		(ce && idx == IDX_SOCKET_INTERFACE_STATUS) |=> rdata[STAT_ALWAYS_ONE_BIT];
	endproperty
	a_stat_top: assert property (p_stat_top) else $error("status bit 7 not one"); // RL1

	property p_ready;
		@(posedge clk) disable iff (rst)
		(ce && idx == IDX_SOCKET_INTERFACE_STATUS)
			|=> rdata[STAT_READY_BIT] == $past(pins.card_ready_irq_pin);
	endproperty
	a_ready: assert property (p_ready) else $error("ready bit mismatch"); // RL2

	property p_wp;
		@(posedge clk) disable iff (rst)
		(ce && idx == IDX_SOCKET_INTERFACE_STATUS)
			|=> rdata[STAT_WP_BIT] == $past(pins.write_protect_io16_pin);
	endproperty
	a_wp: assert property (p_wp) else $error("write protect bit mismatch"); // RL3

	property p_cd;
		@(posedge clk) disable iff (rst)
		(ce && idx == IDX_SOCKET_INTERFACE_STATUS)
			|=> rdata[3:2] == ~$past({pins.card_present_n_b, pins.card_present_n_a});
	endproperty
	a_cd: assert property (p_cd) else $error("card detect not inverted"); // RL4

	property p_bvd;
		@(posedge clk) disable iff (rst)
		(ce && idx == IDX_SOCKET_INTERFACE_STATUS)
			|=> rdata[1:0] == $past({pins.battery_sense_b_pin, pins.battery_sense_a_pin});
	endproperty
	a_bvd: assert property (p_bvd) else $error("battery sense mismatch"); // RL5

	property p_rev;
		@(posedge clk) disable iff (rst)
		(ce && idx == IDX_CHIP_REVISION_ID) |=> rdata[5:4] == 2'b00;
	endproperty
	a_rev: assert property (p_rev) else $error("revision middle bits set"); // RL6

	property p_csc;
		@(posedge clk) disable iff (rst)
		(ce && idx == IDX_CARD_STATUS_CHANGE_FLAGS) |=> rdata[7:4] == 4'h0;
	endproperty
	a_csc: assert property (p_csc) else $error("change upper bits set"); // RL7

	property p_set;
		@(posedge clk) disable iff (rst)
		(ce && (ev & st_q.mgmt_cfg[3:0]) != 4'h0) |=> change != 4'h0;
	endproperty
	a_set: assert property (p_set) else $error("enabled event not latched"); // RL10
endmodule

/* src/scrb_top.sv */
// Socket control register bank: indexed per-socket registers over Wishbone.
// Assumes classic Wishbone master; card pins already synchronous.
// ----------------------------------------
// Summary of operation
// RL1 - Interface status bit 7 always reads one.
// RL2 - Status bit 5 shows the live card ready pin level.
// RL3 - Status bit 4 shows the live write-protect pin level.
// RL4 - Status bits 3-2 show inverted card-present pins.
// RL5 - Status bits 1-0 show battery sense pins unchanged.
// RL6 - Revision register is read-only: interface id, two zeros, stepping.
// RL7 - Change register: four read-only flags low, upper bits zero.
// RL8 - Management config: level in 7-4, event enables in 3-0.
// RL9 - Selector picks socket and index; data port reaches that register.
// RL10 - Enabled events set flags; the first socket with flags set, socket 0 first, drives its management level.
// ----------------------------------------
`timescale 1ns/1ps
module scrb_top
	import scrb_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire scrb_pkg::scrb_pins_s SOCK0_PINS,
	input wire scrb_pkg::scrb_pins_s SOCK1_PINS,
	output logic [3:0] MGMT_LEVEL,
	output logic MGMT_IRQ,
	output logic INT_O
);
	import scrb_pkg::*;

	typedef struct packed {
		logic [7:0] selector;
		logic ack;
		logic [31:0] dat;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
		logic [3:0] level;
		logic mgmt;
		logic intr;
		logic pend_rd;
		logic [3:0] pend_adr;
	} scrb_top_s;

	scrb_top_s r_q, r_d;
	scrb_pins_s pins [NUM_SOCKETS];
	logic [7:0] s_rdata [NUM_SOCKETS];
	logic [3:0] s_change [NUM_SOCKETS];
	logic [3:0] s_level [NUM_SOCKETS];
	logic [1:0] s_event;
	logic req, bus_wr, data_rd;

	assign pins[0] = SOCK0_PINS;
	assign pins[1] = SOCK1_PINS;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign req = WB_CYC_I & WB_STB_I & ~r_q.ack & ~r_q.pend_rd;
	assign bus_wr = req & WB_WE_I & WB_SEL_I[0];
	assign data_rd = req & ~WB_WE_I & (WB_ADR_I == OFS_DATA_PORT);

	// ----------------------------------------
	// Sockets
	// ----------------------------------------
	generate
		for (genvar s = 0; s < NUM_SOCKETS; s++) begin : g_sock
			logic hit;
			// RL9 - socket routing
			assign hit = (r_q.selector[SEL_SOCKET_BIT] == 1'(s));
			scrb_socket_regs u_regs (
				.clk(CORE_CLK),
				.rst(SYS_RST),
				.ce(CLK_EN),
				.pins(pins[s]),
				.wr(bus_wr & hit & (WB_ADR_I == OFS_DATA_PORT)),
				.rd(data_rd & hit),
				.idx(r_q.selector[5:0]),
				.wdata(WB_DAT_I[7:0]),
				.rdata(s_rdata[s]),
				.change(s_change[s]),
				.mgmt_level(s_level[s]),
				.event_any(s_event[s])
			);
		end
	endgenerate

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.ack = 1'b0;
		// Reads of the data port wait one cycle for the socket's read register
		if (r_q.pend_rd) begin
			r_d.pend_rd = 1'b0;
			r_d.ack = 1'b1;
			r_d.dat = {24'h0, s_rdata[r_q.selector[SEL_SOCKET_BIT]]};
		end else if (req) begin
			if (data_rd) begin
				r_d.pend_rd = 1'b1;
			end else begin
				r_d.ack = 1'b1;
				r_d.dat = 32'h0000_0000;
				unique case (WB_ADR_I)
					OFS_SELECTOR: r_d.dat = {24'h0, r_q.selector};
					OFS_IRQ_STATUS: r_d.dat = {30'h0, r_q.irq_stat};
					OFS_IRQ_ENABLE: r_d.dat = {30'h0, r_q.irq_en};
					default: r_d.dat = 32'h0000_0000;
				endcase
			end
		end
		// RL9 - selector write
		if (bus_wr && WB_ADR_I == OFS_SELECTOR) begin
			r_d.selector = {1'b0, WB_DAT_I[6:0]};
		end
		if (bus_wr && WB_ADR_I == OFS_IRQ_ENABLE) begin
			r_d.irq_en = WB_DAT_I[1:0];
		end
		if (bus_wr && WB_ADR_I == OFS_IRQ_CLEAR) begin
			r_d.irq_stat = r_q.irq_stat & ~WB_DAT_I[1:0];
		end
		// Set wins over clear
		r_d.irq_stat = r_d.irq_stat | s_event;
		// RL10 - drive level of the first socket with flags set, socket 0 first
		r_d.mgmt = 1'b0;
		r_d.level = 4'h0;
		if (s_change[0] != 4'h0) begin
			r_d.mgmt = 1'b1;
			r_d.level = s_level[0];
		end else if (s_change[1] != 4'h0) begin
			r_d.mgmt = 1'b1;
			r_d.level = s_level[1];
		end
		r_d.intr = |(r_d.irq_stat & r_d.irq_en);
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			r_q <= '0;
		end else if (CLK_EN) begin
			r_q <= r_d;
		end
	end

	assign WB_ACK_O = r_q.ack;
	assign WB_DAT_O = r_q.dat;
	assign MGMT_LEVEL = r_q.level;
	assign MGMT_IRQ = r_q.mgmt;
	assign INT_O = r_q.intr;

	// RL9 - selector capture
	property p_sel;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && bus_wr && WB_ADR_I == OFS_SELECTOR)
			|=> r_q.selector[6:0] == $past(WB_DAT_I[6:0]);
	endproperty
	a_sel: assert property (p_sel) else $error("selector not updated"); // RL9

	// RL10 - level follows socket
	property p_mgmt;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && s_change[0] != 4'h0) |=> MGMT_IRQ && MGMT_LEVEL == $past(s_level[0]);
	endproperty
	a_mgmt: assert property (p_mgmt) else $error("management level not driven"); // RL10

	// ----------------------------------------
	// Bus handshake checks
	// ----------------------------------------
	// RL9 - ack one cycle
	property p_ack_pulse;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && WB_ACK_O) |=> !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long"); // RL9

	// RL9 - writes answer next
	property p_ack_write;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && req && WB_WE_I) |=> WB_ACK_O;
	endproperty
	a_ack_write: assert property (p_ack_write) else $error("write not acknowledged"); // RL9

	// RL9 - direct reads answer
	property p_ack_read;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && req && !WB_WE_I && WB_ADR_I != OFS_DATA_PORT) |=> WB_ACK_O;
	endproperty
	a_ack_read: assert property (p_ack_read) else $error("read not acknowledged"); // RL9

	// RL9 - port read waits
	property p_port_wait;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && data_rd) |=> !WB_ACK_O && r_q.pend_rd;
	endproperty
	a_port_wait: assert property (p_port_wait) else $error("port read answered early"); // RL9

	// RL9 - port read answers
	property p_port_ack;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && r_q.pend_rd) |=> WB_ACK_O;
	endproperty
	a_port_ack: assert property (p_port_ack) else $error("port read not answered"); // RL9

	// RL9 - selected socket data
	property p_port_data;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && r_q.pend_rd)
			|=> WB_DAT_O == {24'h00_0000, $past(s_rdata[r_q.selector[SEL_SOCKET_BIT]])};
	endproperty
	a_port_data: assert property (p_port_data) else $error("wrong socket data"); // RL9

	// RL9 - no stray ack
	property p_ack_idle;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && !(WB_CYC_I && WB_STB_I) && !r_q.pend_rd) |=> !WB_ACK_O;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request"); // RL9

	// RL9 - upper data zero
	property p_dat_upper;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000;
	endproperty
	a_dat_upper: assert property (p_dat_upper) else $error("upper read data set"); // RL9

	// RL9 - masked write ignored
	property p_sel_lane;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && req && WB_WE_I && !WB_SEL_I[0])
			|=> $stable(r_q.selector) && $stable(r_q.irq_en);
	endproperty
	a_sel_lane: assert property (p_sel_lane) else $error("masked write took effect"); // RL9

	// ----------------------------------------
	// Selector checks
	// ----------------------------------------
	// RL9 - reserved bit zero
	property p_sel_rsvd;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && bus_wr && WB_ADR_I == OFS_SELECTOR) |=> !r_q.selector[7];
	endproperty
	a_sel_rsvd: assert property (p_sel_rsvd) else $error("selector bit 7 set"); // RL9

	// RL9 - selector holds
	property p_sel_hold;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && !(bus_wr && WB_ADR_I == OFS_SELECTOR)) |=> $stable(r_q.selector);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selector moved unwritten"); // RL9

	// RL9 - selector read back
	property p_sel_read;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && req && !WB_WE_I && WB_ADR_I == OFS_SELECTOR)
			|=> WB_DAT_O == {24'h00_0000, $past(r_q.selector)};
	endproperty
	a_sel_read: assert property (p_sel_read) else $error("selector read wrong"); // RL9

	// ----------------------------------------
	// Interrupt and management checks
	// ----------------------------------------
	// RL10 - enable capture
	property p_en_write;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && bus_wr && WB_ADR_I == OFS_IRQ_ENABLE)
			|=> r_q.irq_en == $past(WB_DAT_I[1:0]);
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable not written"); // RL10

	// RL10 - events stick
	property p_stat_set;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && s_event != 2'b00) |=> (r_q.irq_stat & $past(s_event)) == $past(s_event);
	endproperty
	a_stat_set: assert property (p_stat_set) else $error("event not latched"); // RL10

	// RL10 - clear drops bits
	property p_stat_clear;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && bus_wr && WB_ADR_I == OFS_IRQ_CLEAR && s_event == 2'b00)
			|=> (r_q.irq_stat & $past(WB_DAT_I[1:0])) == 2'b00;
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status not cleared"); // RL10

	// RL10 - interrupt level
	property p_int_level;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		INT_O == |(r_q.irq_stat & r_q.irq_en);
	endproperty
	a_int_level: assert property (p_int_level) else $error("interrupt level wrong"); // RL10

	// RL10 - quiet when clear
	property p_mgmt_idle;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && s_change[0] == 4'h0 && s_change[1] == 4'h0)
			|=> !MGMT_IRQ && MGMT_LEVEL == 4'h0;
	endproperty
	a_mgmt_idle: assert property (p_mgmt_idle) else $error("management not idle"); // RL10

	// RL10 - second socket level
	property p_mgmt_sock1;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(CLK_EN && s_change[0] == 4'h0 && s_change[1] != 4'h0)
			|=> MGMT_IRQ && MGMT_LEVEL == $past(s_level[1]);
	endproperty
	a_mgmt_sock1: assert property (p_mgmt_sock1) else $error("socket 1 level wrong"); // RL10

	// RL10 - enable low freezes
	property p_freeze;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		!CLK_EN |=> $stable(r_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // RL10
endmodule

/* verification/scrb_card_model.sv */
// Behavioural card for one socket: drives the six card pins.
// Assumes bench commands change just after a rising clock edge.
`timescale 1ns/1ps
module scrb_card_model
	import scrb_pkg::*;
(
	input wire logic clk,
	input wire logic seated,
	input wire logic [3:0] lvl,
	output scrb_pkg::scrb_pins_s pins
);
	// Empty socket leaves every line on its pull-up
	always_ff @(posedge clk) begin
		pins <= seated ? {lvl[3:2], 2'b00, lvl[1:0]} : 6'h3F;
	end
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the socket control register bank.
// Assumes the package and the card model are compiled first.
`timescale 1ns/1ps
module tb_top;
	import scrb_pkg::*;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ce = 1;
	logic [3:0] adr = 4'h0, sel = 4'hF, ml;
	logic [31:0] wdat = 32'h0000_0000, rd, t;
	logic ack, mirq, int_o;
	logic [3:0] mlvl;
	logic [1:0] seat = 2'b11, en, pw;
	logic [1:0][3:0] lvl = 8'h00;
	logic [7:0] v0, v1;
	scrb_pins_s p0, p1;
	int n_mismatch = 0, checked = 0;

	always #2 clk = ~clk;

	scrb_card_model i_card0 (.clk(clk), .seated(seat[0]), .lvl(lvl[0]), .pins(p0));
	scrb_card_model i_card1 (.clk(clk), .seated(seat[1]), .lvl(lvl[1]), .pins(p1));
	scrb_top i_dut (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
		.WB_DAT_O(rd), .WB_ACK_O(ack), .SOCK0_PINS(p0), .SOCK1_PINS(p1),
		.MGMT_LEVEL(mlvl), .MGMT_IRQ(mirq), .INT_O(int_o));

	// ----------------------------------------
	// Compare and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [7:0] exp);
		checked++;
		if (got !== {24'h00_0000, exp}) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	// Waits for ack under a bound; a lost ack counts as a mismatch
	task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h00_0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) n_mismatch++;
		r = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic ireg(input logic w, input logic s, input logic [5:0] i, input logic [7:0] d,
		output logic [31:0] r);
		xfer(1'b1, OFS_SELECTOR, {1'b0, s, i}, r);
		xfer(w, OFS_DATA_PORT, d, r);
	endtask

	function automatic logic [7:0] exp_stat(input logic st, input logic [3:0] l, input logic p);
		return st ? {1'b1, p, l[3:2], 2'b11, l[1:0]} : {1'b1, p, 6'h33};
	endfunction

	task automatic final_report;
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		final_report;
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'hb1f70ba9));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		for (int s = 0; s < 2; s++) begin
			for (int i = 2; i < 7; i++) begin
				ireg(1'b0, s[0], 6'(i), 8'h00, t);
				chk(t, RST_BYTE);
			end
			ireg(1'b1, s[0], IDX_CHIP_REVISION_ID, 8'($urandom), t);
			ireg(1'b0, s[0], IDX_CHIP_REVISION_ID, 8'h00, t);
			chk(t, {REV_INTERFACE_ID, 2'b00, REV_STEPPING});
		end
		for (int k = 0; k < 8; k++) begin
			for (int i = 2; i < 7; i++) begin
				if (i == 4) continue;
				v0 = 8'($urandom);
				v1 = 8'($urandom);
				ireg(1'b1, 1'b0, 6'(i), v0, t);
				ireg(1'b1, 1'b1, 6'(i), v1, t);
				ireg(1'b0, 1'b0, 6'(i), 8'h00, t);
				chk(t, i == 6 ? v0 & MAP_WRITE_MASK : v0);
				ireg(1'b0, 1'b1, 6'(i), 8'h00, t);
				chk(t, i == 6 ? v1 & MAP_WRITE_MASK : v1);
				if (i == 2) pw = {v1[4], v0[4]};
			end
			ireg(1'b1, 1'b0, IDX_MANAGEMENT_INTERRUPT_CONFIG, 8'h00, t);
			ireg(1'b1, 1'b1, IDX_MANAGEMENT_INTERRUPT_CONFIG, 8'h00, t);
			seat <= 2'($urandom);
			lvl <= 8'($urandom);
			repeat (2) @(posedge clk);
			for (int s = 0; s < 2; s++) begin
				ireg(1'b0, s[0], IDX_SOCKET_INTERFACE_STATUS, 8'h00, t);
				chk(t, exp_stat(seat[s], lvl[s], pw[s]));
			end
		end
		xfer(1'b1, OFS_SELECTOR, 8'hFF, t);
		sel <= 4'hE;
		xfer(1'b1, OFS_SELECTOR, 8'h05, t);
		sel <= 4'hF;
		xfer(1'b0, OFS_SELECTOR, 8'h00, t);
		chk(t, 8'h7F);
		ireg(1'b0, 1'b1, 6'h3F, 8'h00, t);
		chk(t, 8'h00);
		xfer(1'b0, 4'h2, 8'h00, t);
		chk(t, 8'h00);
		for (int s = 0; s < 2; s++) begin
			for (int e = 0; e < 4; e++) begin
				seat <= 2'b11;
				lvl[s] <= 4'h0;
				ml = 4'($urandom);
				en = 2'($urandom);
				repeat (3) @(posedge clk);
				// Enable word sits at 0xC
				xfer(1'b1, OFS_IRQ_ENABLE, {6'h00, en}, t);
				xfer(1'b0, OFS_IRQ_ENABLE, 8'h00, t);
				chk(t, {6'h00, en});
				ireg(1'b1, s[0], IDX_MANAGEMENT_INTERRUPT_CONFIG, {ml, 4'(4'h1 << e)}, t);
				case (e)
					3: seat[s] <= 1'b0;
					2: lvl[s][3] <= 1'b1;
					default: lvl[s][e] <= 1'b1;
				endcase
				repeat (6) @(posedge clk);
				chk_bit(mirq, 1'b1);
				chk({28'h000_0000, mlvl}, {4'h0, ml});
				chk_bit(int_o, en[s]);
				xfer(1'b0, OFS_IRQ_STATUS, 8'h00, t);
				chk(t, 8'(1 << s));
				ireg(1'b0, s[0], IDX_CARD_STATUS_CHANGE_FLAGS, 8'h00, t);
				chk(t, 8'(1 << e));
				ireg(1'b0, s[0], IDX_CARD_STATUS_CHANGE_FLAGS, 8'h00, t);
				chk(t, 8'h00);
				xfer(1'b1, OFS_IRQ_CLEAR, 8'h03, t);
				repeat (3) @(posedge clk);
				chk_bit(int_o, 1'b0);
				chk_bit(mirq, 1'b0);
				ireg(1'b1, s[0], IDX_MANAGEMENT_INTERRUPT_CONFIG, 8'h00, t);
			end
		end
		// Frozen core must not see the card leave until the enable returns
		ireg(1'b1, 1'b0, IDX_MANAGEMENT_INTERRUPT_CONFIG, 8'h08, t);
		ce <= 1'b0;
		seat[0] <= 1'b0;
		repeat (5) @(posedge clk);
		chk_bit(mirq, 1'b0);
		chk_bit(ack, 1'b0);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		chk_bit(mirq, 1'b1);
		chk({28'h000_0000, mlvl}, 8'h00);
		ireg(1'b0, 1'b0, IDX_CARD_STATUS_CHANGE_FLAGS, 8'h00, t);
		chk(t, 8'h08);
		final_report;
	end
endmodule
